// file: hw/nvrb_dev.sv
// nvrb_dev: device end; streams pages of the two non-volatile arrays on request.
// assumes: runs on the link clock; the fill and pointer ports share that clock.
`timescale 1ns/1ps
module nvrb_dev #(
    parameter int PTR_W = nvrb_pkg::PTR_W,
    parameter int IDX_W = nvrb_pkg::IDX_W
) (
    input wire logic rst_n,
    nvrb_if.dev lk,
    input wire logic pgm_we,
    input wire logic pgm_array,
    input wire logic [PTR_W-1:0] pgm_page,
    input wire logic [IDX_W-1:0] pgm_byte,
    input wire logic [7:0] pgm_data,
    input wire logic ptr_load,
    input wire logic [PTR_W-1:0] ptr_value,
    output logic [PTR_W-1:0] page_ptr,
    output logic busy,
    output logic rd_array
);
    localparam int PB = 2 ** IDX_W;

    typedef struct packed {
        nvrb_pkg::nvrb_dst_t st;
        logic arr;
        logic i2c;
        logic [1:0] opn;
        logic [13:0] cnt;
        logic [13:0] emit;
        nvrb_pkg::nvrb_seg_t seg;
        logic [4:0] idx;
        logic [PTR_W-1:0] ptr;
        logic [7:0] d2h;
        logic busy;
    } nvrb_dev_state_t;

    localparam nvrb_dev_state_t RST = '{
        st: nvrb_pkg::DST_IDLE, arr: 1'b0, i2c: 1'b0, opn: 2'h0, cnt: 14'h0000,
        emit: 14'h0000, seg: nvrb_pkg::SEG_PAGE, idx: 5'h00, ptr: '0,
        d2h: nvrb_pkg::IDLE_BYTE, busy: 1'b0};

    nvrb_dev_state_t s_q;
    nvrb_dev_state_t s_d;
    // both arrays live in one memory, the array select being the top address bit
    logic [7:0] mem_q [2 ** (PTR_W + IDX_W + 1)];
    logic [13:0] cnt_eff;
    logic seg_end;
    logic is_read_cmd;

    function automatic logic [7:0] rd_byte(input logic a, input logic [PTR_W-1:0] p,
                                           input logic [IDX_W-1:0] i);
        rd_byte = mem_q[{a, p, i}];
    endfunction

    function automatic logic [4:0] seg_last(input nvrb_pkg::nvrb_seg_t sg);
        case (sg)
            nvrb_pkg::SEG_PAGE: seg_last = 5'(PB - 1);
            nvrb_pkg::SEG_FILL: seg_last = 5'(nvrb_pkg::FILL_CNT - 1);
            default: seg_last = 5'(nvrb_pkg::DUMMY_CNT - 1);
        endcase
    endfunction

    always_ff @(posedge lk.lk_clk)
    begin
        if (pgm_we)
            mem_q[{pgm_array, pgm_page, pgm_byte}] <= pgm_data;
    end

    // a zero count behaves as a single page
    assign cnt_eff = (s_q.cnt == 14'h0000) ? 14'h0001 : s_q.cnt;
    assign seg_end = (s_q.idx == seg_last(s_q.seg));
    assign is_read_cmd = (lk.lk_h2d == nvrb_pkg::CMD_RD_CFG)
                       || (lk.lk_h2d == nvrb_pkg::CMD_RD_USR);

    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            nvrb_pkg::DST_IDLE:
            begin
                if (ptr_load)
                    s_d.ptr = ptr_value;
                if (!lk.lk_sel_n && lk.lk_valid)
                begin
                    if (is_read_cmd)
                    begin
                        s_d.st = nvrb_pkg::DST_OPS;
                        s_d.arr = (lk.lk_h2d == nvrb_pkg::CMD_RD_USR);
                        s_d.i2c = lk.lk_i2c;
                        s_d.opn = 2'h0;
                        s_d.cnt = 14'h0000;
                        s_d.busy = 1'b1;
                        // page fetch begins here, overlapping the operand bytes
                        s_d.d2h = rd_byte(s_d.arr, s_q.ptr, '0);
                    end
                    else
                        s_d.st = nvrb_pkg::DST_DRAIN;
                end
            end
            nvrb_pkg::DST_OPS:
            begin
                if (lk.lk_valid)
                begin
                    s_d.cnt = {s_q.cnt[5:0], lk.lk_h2d};
                    s_d.opn = s_q.opn + 2'h1;
                    if (s_q.opn == (s_q.i2c ? 2'(nvrb_pkg::OPS_I2C - 1)
                                            : 2'(nvrb_pkg::OPS_FULL - 1)))
                    begin
                        s_d.st = s_q.i2c ? nvrb_pkg::DST_WAIT_RS : nvrb_pkg::DST_DATA;
                        s_d.seg = nvrb_pkg::SEG_PAGE;
                        s_d.idx = 5'h00;
                        s_d.emit = 14'h0000;
                    end
                end
            end
            nvrb_pkg::DST_WAIT_RS:
            begin
                // first byte was already fetched at command time
                if (lk.lk_rs)
                    s_d.st = nvrb_pkg::DST_DATA;
            end
            nvrb_pkg::DST_DATA:
            begin
                if (lk.lk_valid)
                begin
                    if (!seg_end)
                        s_d.idx = s_q.idx + 5'h01;
                    else
                    begin
                        s_d.idx = 5'h00;
                        case (s_q.seg)
                            nvrb_pkg::SEG_PAGE:
                            begin
                                s_d.emit = s_q.emit + 14'h0001;
                                if (s_q.emit != 14'h0000)
                                    s_d.ptr = s_q.ptr + 1'b1;
                                if (s_q.i2c && !(s_d.emit >= cnt_eff && s_q.emit == 14'h0000))
                                    s_d.seg = (s_q.emit == 14'h0000) ? nvrb_pkg::SEG_FILL
                                                                     : nvrb_pkg::SEG_DUMMY;
                                else if (s_d.emit >= cnt_eff)
                                    s_d.st = nvrb_pkg::DST_DRAIN;
                                else
                                    s_d.seg = nvrb_pkg::SEG_PAGE;
                            end
                            nvrb_pkg::SEG_FILL:
                                s_d.seg = nvrb_pkg::SEG_PAGE;
                            default:
                            begin
                                if (s_q.emit >= cnt_eff)
                                    s_d.st = nvrb_pkg::DST_DRAIN;
                                else
                                    s_d.seg = nvrb_pkg::SEG_PAGE;
                            end
                        endcase
                    end
                    if (s_d.st == nvrb_pkg::DST_DRAIN)
                        s_d.d2h = nvrb_pkg::IDLE_BYTE;
                    else if (s_d.seg == nvrb_pkg::SEG_PAGE)
                        s_d.d2h = rd_byte(s_q.arr, s_d.ptr, s_d.idx[IDX_W-1:0]);
                    else if (s_d.seg == nvrb_pkg::SEG_FILL)
                        s_d.d2h = nvrb_pkg::FILL_BYTE;
                    else
                        s_d.d2h = nvrb_pkg::DUMMY_BYTE;
                end
            end
            nvrb_pkg::DST_DRAIN:
                s_d.d2h = nvrb_pkg::IDLE_BYTE;
            default:
                s_d = RST;
        endcase
        // deselect ends the frame at any point, pending command included
        if (lk.lk_sel_n && s_q.st != nvrb_pkg::DST_IDLE)
        begin
            s_d.st = nvrb_pkg::DST_IDLE;
            s_d.busy = 1'b0;
            s_d.d2h = nvrb_pkg::IDLE_BYTE;
        end
    end

    always_ff @(posedge lk.lk_clk)
    begin
        if (!rst_n)
            s_q <= RST;
        else
            s_q <= s_d;
    end

    assign lk.lk_d2h = s_q.d2h;
    assign page_ptr = s_q.ptr;
    assign busy = s_q.busy;
    assign rd_array = s_q.arr;
endmodule

// file: hw/nvrb_host.sv
// nvrb_host: configuration host end; issues page read commands and collects bytes.
// assumes: the link clock is made here by dividing sys_clk and runs except while rst_n holds it low.
`timescale 1ns/1ps
module nvrb_host #(
    parameter int HALF = nvrb_pkg::LK_HALF,
    parameter int RETR_NS = nvrb_pkg::RETR_NS_LARGE,
    parameter int PB = 2 ** nvrb_pkg::IDX_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    nvrb_if.host lk,
    input wire logic req,
    input wire logic req_array,
    input wire logic req_i2c,
    input wire logic req_wb,
    input wire logic [13:0] req_pages,
    output logic ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done
);
    localparam int PER_NS = 2 * HALF * nvrb_pkg::SYS_PERIOD_NS;
    localparam int GAPS_RAW = (RETR_NS + PER_NS - 1) / PER_NS - 1;
    localparam int GAPS = (GAPS_RAW > 0) ? GAPS_RAW : 0;

    typedef struct packed {
        nvrb_pkg::nvrb_hst_t st;
        logic [7:0] div;
        logic clk;
        logic sel_n;
        logic valid;
        logic rs;
        logic i2c;
        logic arr;
        logic [7:0] h2d;
        logic [23:0] operand_bytes;
        logic [1:0] opn;
        logic [7:0] gap;
        logic [23:0] left;
        logic pend;
        logic ready;
        logic rd_valid;
        logic [7:0] rd_data;
        logic done;
    } nvrb_host_state_t;

    localparam nvrb_host_state_t RST = '{
        st: nvrb_pkg::HST_IDLE, div: 8'h00, clk: 1'b0, sel_n: 1'b1, valid: 1'b0,
        rs: 1'b0, i2c: 1'b0, arr: 1'b0, h2d: nvrb_pkg::IDLE_BYTE, operand_bytes: 24'h000000,
        opn: 2'h0, gap: 8'h00, left: 24'h000000, pend: 1'b0, ready: 1'b1,
        rd_valid: 1'b0, rd_data: 8'h00, done: 1'b0};

    nvrb_host_state_t s_q;
    nvrb_host_state_t s_d;
    logic [7:0] d2h_sync;
    logic [13:0] cnt_send;

    // bytes to collect for the pages wanted; trailing dummies are never read
    function automatic logic [23:0] nvrb_total(input logic i2c, input logic [13:0] p);
        logic [23:0] pp;
        pp = {10'h000, p};
        if (p <= 14'h0001)
            nvrb_total = 24'(PB);
        else if (i2c)
            nvrb_total = 24'(3 * PB) + (pp - 24'h000001) * 24'(PB + nvrb_pkg::DUMMY_CNT);
        else
            nvrb_total = (pp + 24'h000001) * 24'(PB);
    endfunction

    // limitation: HALF below 3 reads a returned byte one link period late
    nvrb_sync2 #(
        .W(8)
    ) u_d2h_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din(lk.lk_d2h),
        .dout(d2h_sync)
    );

    always_comb
    begin
        if (req_wb && req_pages >= nvrb_pkg::WB_BIG_PAGES)
            cnt_send = nvrb_pkg::CNT_MAX;
        else if (req_pages <= 14'h0001)
            cnt_send = 14'h0001;
        else if (req_pages == nvrb_pkg::CNT_MAX)
            cnt_send = nvrb_pkg::CNT_MAX;
        else
            cnt_send = req_pages + 14'h0001;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        s_d.done = 1'b0;
        s_d.div = s_q.div + 8'h01;
        if (req && s_q.ready)
        begin
            s_d.pend = 1'b1;
            s_d.ready = 1'b0;
            s_d.i2c = req_i2c;
            s_d.arr = req_array;
            // i2c sends two operand bytes, the others three
            s_d.operand_bytes = req_i2c ? {2'b00, cnt_send, 8'h00} : {8'h00, 2'b00, cnt_send};
            s_d.left = nvrb_total(req_i2c, req_pages);
        end
        if (s_q.div == 8'(HALF - 1))
        begin
            s_d.div = 8'h00;
            s_d.clk = ~s_q.clk;
            if (s_q.clk)
            begin
                case (s_q.st)
                    nvrb_pkg::HST_IDLE:
                    begin
                        if (s_q.pend)
                        begin
                            s_d.pend = 1'b0;
                            s_d.sel_n = 1'b0;
                            s_d.valid = 1'b1;
                            s_d.h2d = s_q.arr ? nvrb_pkg::CMD_RD_USR : nvrb_pkg::CMD_RD_CFG;
                            s_d.opn = 2'h0;
                            s_d.gap = 8'(GAPS);
                            s_d.st = (GAPS == 0) ? nvrb_pkg::HST_OPS : nvrb_pkg::HST_GAP;
                        end
                    end
                    nvrb_pkg::HST_GAP:
                    begin
                        // idle slots stretch command-to-first-operand to the retrieval time
                        s_d.valid = 1'b0;
                        s_d.gap = s_q.gap - 8'h01;
                        if (s_q.gap == 8'h01)
                            s_d.st = nvrb_pkg::HST_OPS;
                    end
                    nvrb_pkg::HST_OPS:
                    begin
                        s_d.valid = 1'b1;
                        s_d.h2d = s_q.operand_bytes[23:16];
                        s_d.operand_bytes = {s_q.operand_bytes[15:0], 8'h00};
                        s_d.opn = s_q.opn + 2'h1;
                        if (s_q.opn == (s_q.i2c ? 2'(nvrb_pkg::OPS_I2C - 1)
                                                : 2'(nvrb_pkg::OPS_FULL - 1)))
                            s_d.st = s_q.i2c ? nvrb_pkg::HST_RS : nvrb_pkg::HST_DATA;
                    end
                    nvrb_pkg::HST_RS:
                    begin
                        // repeated start: the frame stays selected
                        s_d.valid = 1'b0;
                        s_d.rs = 1'b1;
                        s_d.st = nvrb_pkg::HST_DATA;
                    end
                    nvrb_pkg::HST_DATA:
                    begin
                        s_d.rs = 1'b0;
                        s_d.rd_valid = 1'b1;
                        s_d.rd_data = d2h_sync;
                        s_d.left = s_q.left - 24'h000001;
                        if (s_q.left == 24'h000001)
                        begin
                            s_d.sel_n = 1'b1;
                            s_d.valid = 1'b0;
                            s_d.h2d = nvrb_pkg::IDLE_BYTE;
                            s_d.done = 1'b1;
                            s_d.ready = 1'b1;
                            s_d.st = nvrb_pkg::HST_IDLE;
                        end
                        else
                        begin
                            s_d.valid = 1'b1;
                            s_d.h2d = nvrb_pkg::IDLE_BYTE;
                        end
                    end
                    default:
                        s_d = RST;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            s_q <= RST;
        else
            s_q <= s_d;
    end

    assign lk.lk_clk = s_q.clk;
    assign lk.lk_sel_n = s_q.sel_n;
    assign lk.lk_valid = s_q.valid;
    assign lk.lk_rs = s_q.rs;
    assign lk.lk_i2c = s_q.i2c;
    assign lk.lk_h2d = s_q.h2d;
    assign ready = s_q.ready;
    assign rd_valid = s_q.rd_valid;
    assign rd_data = s_q.rd_data;
    assign done = s_q.done;
endmodule

// file: hw/nvrb_if.sv
// nvrb_if: the readback link between the configuration host and the device.
// assumes: the host end makes lk_clk and changes its outputs on the falling edge, save lk_i2c, which is set when a request is taken.
`timescale 1ns/1ps
interface nvrb_if;
    logic lk_clk;
    logic lk_sel_n;
    logic lk_valid;
    logic lk_rs;
    logic lk_i2c;
    logic [7:0] lk_h2d;
    logic [7:0] lk_d2h;

    modport host (
        output lk_clk,
        output lk_sel_n,
        output lk_valid,
        output lk_rs,
        output lk_i2c,
        output lk_h2d,
        input lk_d2h
    );

    modport dev (
        input lk_clk,
        input lk_sel_n,
        input lk_valid,
        input lk_rs,
        input lk_i2c,
        input lk_h2d,
        output lk_d2h
    );
endinterface

// file: hw/nvrb_pkg.sv
// nvrb_pkg: constants and types shared by both ends of the page readback link.
// assumes: byte-wide link, one byte exchanged per rising edge of the link clock.
package nvrb_pkg;
    localparam int PTR_W = 6;
    localparam int IDX_W = 4;
    localparam int CNT_W = 14;
    localparam logic [13:0] CNT_MAX = 14'h3fff;
    localparam logic [13:0] WB_BIG_PAGES = 14'h000d;
    localparam int FILL_CNT = 16;
    localparam int DUMMY_CNT = 4;
    localparam int OPS_FULL = 3;
    localparam int OPS_I2C = 2;
    localparam logic [7:0] CMD_RD_CFG = 8'h73;
    localparam logic [7:0] CMD_RD_USR = 8'hca;
    localparam logic [7:0] FILL_BYTE = 8'h5a;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam int SYS_PERIOD_NS = 5;
    localparam int LK_HALF = 12;
    localparam int RETR_NS_LARGE = 240;
    localparam int RETR_NS_SMALL = 360;

    typedef enum logic [2:0] {
        SEG_PAGE = 3'b001,
        SEG_FILL = 3'b010,
        SEG_DUMMY = 3'b100
    } nvrb_seg_t;

    typedef enum logic [4:0] {
        DST_IDLE = 5'b00001,
        DST_OPS = 5'b00010,
        DST_WAIT_RS = 5'b00100,
        DST_DATA = 5'b01000,
        DST_DRAIN = 5'b10000
    } nvrb_dst_t;

    typedef enum logic [4:0] {
        HST_IDLE = 5'b00001,
        HST_GAP = 5'b00010,
        HST_OPS = 5'b00100,
        HST_RS = 5'b01000,
        HST_DATA = 5'b10000
    } nvrb_hst_t;
endpackage

// file: hw/nvrb_sync2.sv
// nvrb_sync2: two-flop synchroniser for a level or a word held stable long enough.
// assumes: a word is only read after it has stood still for several clocks.
`timescale 1ns/1ps
module nvrb_sync2 #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// file: sim/nv_page_readback_sequencer_tb.sv
// nv_page_readback_sequencer_tb: host and device ends joined by the link, read scenarios.
// assumes: the host end divides sys_clk to make the link clock.
`timescale 1ns/1ps
module nv_page_readback_sequencer_tb;
    // the host reads returned bytes through two sys_clk flops, so HALF must be 3 or more
    localparam int HALF = 4;
    localparam int PER = 2 * HALF * nvrb_pkg::SYS_PERIOD_NS;
    localparam int GAPS = (nvrb_pkg::RETR_NS_LARGE + PER - 1) / PER - 1;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic dev_rst_n = 1'b0;
    logic req = 1'b0;
    logic req_array = 1'b0;
    logic req_i2c = 1'b0;
    logic req_wb = 1'b0;
    logic [13:0] req_pages = 14'h0001;
    logic ready, rd_valid, done, busy, rd_array;
    logic [7:0] rd_data;
    logic pgm_we = 1'b0;
    logic pgm_array = 1'b0;
    logic [5:0] pgm_page = 6'h00;
    logic [3:0] pgm_byte = 4'h0;
    logic [7:0] pgm_data = 8'h00;
    logic ptr_load = 1'b0;
    logic [5:0] ptr_value = 6'h00;
    logic [5:0] page_ptr;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] got_q[$];
    logic [8:0] exp_q[$];
    nvrb_if lk_if ();
    nvrb_host #(.HALF(HALF)) nvrb_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lk(lk_if),
        .req(req), .req_array(req_array), .req_i2c(req_i2c), .req_wb(req_wb),
        .req_pages(req_pages), .ready(ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .done(done));
    nvrb_dev nvrb_dev_inst (.rst_n(dev_rst_n), .lk(lk_if), .pgm_we(pgm_we),
        .pgm_array(pgm_array), .pgm_page(pgm_page), .pgm_byte(pgm_byte), .pgm_data(pgm_data),
        .ptr_load(ptr_load), .ptr_value(ptr_value), .page_ptr(page_ptr), .busy(busy),
        .rd_array(rd_array));
    nvrb_asserts #(.GAPS(GAPS)) nvrb_asserts_inst (.lk_clk(lk_if.lk_clk), .rst_n(dev_rst_n),
        .lk_sel_n(lk_if.lk_sel_n), .lk_valid(lk_if.lk_valid), .lk_rs(lk_if.lk_rs),
        .lk_i2c(lk_if.lk_i2c), .lk_h2d(lk_if.lk_h2d), .lk_d2h(lk_if.lk_d2h));
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // bit 7 kept low so no stored byte can pass for the idle value
    function automatic logic [7:0] pat(input logic a, input logic [5:0] p, input logic [3:0] i);
        return {1'b0, a, p} ^ {4'h0, i};
    endfunction
    task automatic check(input logic [8:0] exp, input logic [7:0] got, input string what);
        total_checks++;
        if (!exp[8] && got !== exp[7:0])
        begin
            miscompares++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp[7:0]);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 2000)
        begin
            @(negedge lk_if.lk_clk);
            t++;
        end
        if (t == 2000)
        begin
            miscompares++;
            $display("BAD %0t device stuck busy", $time);
            complete_run();
        end
    endtask
    task automatic fill();
        for (int k = 0; k < 2048; k++)
        begin
            @(negedge lk_if.lk_clk);
            pgm_we = 1'b1;
            pgm_array = k[10];
            pgm_page = k[9:4];
            pgm_byte = k[3:0];
            pgm_data = pat(k[10], k[9:4], k[3:0]);
        end
        @(negedge lk_if.lk_clk);
        pgm_we = 1'b0;
    endtask
    task automatic issue(input logic a, input logic i2c, input logic wb, input int n);
        @(negedge sys_clk);
        req = 1'b1;
        req_array = a;
        req_i2c = i2c;
        req_wb = wb;
        req_pages = 14'(n);
        @(negedge sys_clk);
        req = 1'b0;
    endtask
    task automatic rd(input logic a, input logic i2c, input logic wb, input int n,
        input logic [5:0] p);
        int t;
        logic [5:0] pg;
        got_q.delete();
        exp_q.delete();
        wait_idle();
        @(negedge lk_if.lk_clk);
        ptr_load = 1'b1;
        ptr_value = p;
        @(negedge lk_if.lk_clk);
        ptr_load = 1'b0;
        issue(a, i2c, wb, n);
        check(9'h000, {7'h00, ready}, "ready while taken");
        t = 0;
        while (done !== 1'b1 && t < 40000)
        begin
            @(negedge sys_clk);
            if (rd_valid === 1'b1)
                got_q.push_back(rd_data);
            t++;
        end
        check(9'h001, {7'h00, ready}, "ready after done");
        // past one page the first page repeats; i2c puts fillers before and dummies ahead of later pages
        for (int k = 0; k < n + int'(n > 1); k++)
        begin
            pg = p + 6'(k > 0 ? k - 1 : 0);
            if (i2c && k == 1)
                repeat (nvrb_pkg::FILL_CNT) exp_q.push_back(9'h100);
            if (i2c && k > 1)
                repeat (nvrb_pkg::DUMMY_CNT) exp_q.push_back({1'b0, nvrb_pkg::DUMMY_BYTE});
            for (int b = 0; b < 16; b++)
                exp_q.push_back({1'b0, pat(a, pg, b[3:0])});
        end
        check({1'b0, 8'(exp_q.size())}, 8'(got_q.size()), "byte count");
        for (int k = 0; k < exp_q.size() && k < got_q.size(); k++)
            check(exp_q[k], got_q[k], "page byte");
        wait_idle();
        if (!wb)
            // the last page is left by deselect, so the pointer stays on it
            check({3'b000, p + 6'(n - 1)}, {2'b00, page_ptr}, "pointer");
        check({8'h00, a}, {7'h00, rd_array}, "array");
        $display("test end arr %0d i2c %0d wb %0d pages %0d", a, i2c, wb, n);
    endtask
    initial
    begin
        #200us;
        miscompares++;
        complete_run();
    end
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge lk_if.lk_clk);
        dev_rst_n = 1'b1;
        fill();
        rd(1'b0, 1'b0, 1'b0, 1, 6'h05);
        rd(1'b1, 1'b0, 1'b0, 3, 6'h0a);
        rd(1'b0, 1'b1, 1'b0, 1, 6'h00);
        rd(1'b1, 1'b1, 1'b0, 3, 6'h14);
        rd(1'b0, 1'b1, 1'b0, 2, 6'h3d);
        rd(1'b0, 1'b0, 1'b1, 13, 6'h28);
        rd(1'b1, 1'b0, 1'b1, 12, 6'h02);
        // host reset in mid-data deselects the link; the device must drop the command
        issue(1'b1, 1'b0, 1'b0, 12);
        repeat (300) @(negedge sys_clk);
        check(9'h001, {7'h00, busy}, "busy before abort");
        rst_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge lk_if.lk_clk);
        check(9'h000, {7'h00, busy}, "abandon");
        $display("test end abort");
        rd(1'b0, 1'b0, 1'b0, 2, 6'h00);
        complete_run();
    end
endmodule

// file: sim/nvrb_asserts.sv
// nvrb_asserts: slot-level checks on the readback link between host and device ends.
// assumes: link signals are sampled on the link clock rise, under the device reset.
`timescale 1ns/1ps
module nvrb_asserts #(
    parameter int GAPS = 11
) (
    input wire logic lk_clk,
    input wire logic rst_n,
    input wire logic lk_sel_n,
    input wire logic lk_valid,
    input wire logic lk_rs,
    input wire logic lk_i2c,
    input wire logic [7:0] lk_h2d,
    input wire logic [7:0] lk_d2h
);
    logic sel_q;
    logic [7:0] cnt_q;
    logic start;
    assign start = !lk_sel_n && sel_q;
    // slot counter since the opcode, saturating at 255, so slot positions below 255 are checked exactly
    always_ff @(posedge lk_clk)
    begin
        if (!rst_n)
        begin
            sel_q <= 1'b1;
            cnt_q <= 8'h00;
        end
        else
        begin
            sel_q <= lk_sel_n;
            if (start)
                cnt_q <= 8'h01;
            else if (!lk_sel_n && cnt_q != 8'hff)
                cnt_q <= cnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge lk_clk);
    endclocking
    default disable iff (!rst_n);
    property p_cmd;
        start |-> lk_valid && (lk_h2d == nvrb_pkg::CMD_RD_CFG || lk_h2d == nvrb_pkg::CMD_RD_USR);
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("frame opens without a read opcode");
    property p_fetch;
        start |=> lk_d2h != nvrb_pkg::IDLE_BYTE;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("no page byte right after the opcode");
    property p_gap;
        !start && !lk_sel_n && cnt_q != 8'h00 && cnt_q <= GAPS |-> !lk_valid;
    endproperty
    a_gap: assert property (p_gap)
        else $error("operand sent inside the retrieval delay");
    property p_shift;
        !start && !lk_sel_n && !lk_rs && cnt_q > GAPS |-> lk_valid;
    endproperty
    a_shift: assert property (p_shift)
        else $error("host stopped shifting inside a frame");
    property p_op0;
        !start && !lk_sel_n && !lk_i2c && cnt_q == GAPS + 1 |-> lk_h2d == 8'h00;
    endproperty
    a_op0: assert property (p_op0)
        else $error("first count byte not zero");
    property p_rs_slot;
        lk_rs |-> lk_i2c && !lk_sel_n && !lk_valid && cnt_q == GAPS + 3 ##1 !lk_rs;
    endproperty
    a_rs_slot: assert property (p_rs_slot)
        else $error("repeated start out of place");
    property p_rs_due;
        !start && !lk_sel_n && lk_i2c && cnt_q == GAPS + 3 |-> lk_rs;
    endproperty
    a_rs_due: assert property (p_rs_due)
        else $error("repeated start missing");
    property p_stop;
        lk_sel_n |=> lk_d2h == nvrb_pkg::IDLE_BYTE;
    endproperty
    a_stop: assert property (p_stop)
        else $error("device not idle after deselect");
    c_jtag: cover property (start && !lk_i2c);
    c_rs: cover property (lk_rs);
    c_end: cover property (!lk_sel_n ##1 lk_sel_n);
endmodule
